// [core/isarq_pkg.sv]
// Notes on behaviour
// R01: Eight identical SAR sections run concurrently, rotating.
// R02: Sixteen cycles: zero, auto-zero, calibrate, sample, convert, transfer.
// R03: Sixteen-phase generator from the single clock.
// R04: Neighbouring sections lag by two clocks.
// R05: Phase generator wraps after sixteen clocks.
// R06: One result every two input clocks.
// R07: Result appears thirteen clocks after its sample.
// R08: Eleven-bit eight-to-one output multiplexer.
// R09: Auto-zero integrates many comparator decisions.
// R10: Closed-loop MSB and LSB gain correction per section.
// R11: Only the sampling section connects to input.
// R12: Calibration starts at power-up, fine steps.
// R13: Ten thousand clocks before calibration is trusted.
// R14: Clock must run continuously for calibration.
// R15: Background loop keeps calibration after convergence.
// R16: Registered output word, released while enable high.
// R17: Overrange sets flag and forces data ones.
// R18: Data is straight binary, LSB lowest.
// R19: Valid strobe pulses one clock per word.
// R20: Reset starts phase generator at phase zero.
// R21: Multiplexer follows the section in transfer.
package isarq_pkg;

    localparam int unsigned NUM_SECTIONS = 8;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned PHASE_W = 4;
    localparam int unsigned RESULT_W = 11;
    localparam int unsigned DATA_W = 10;
    localparam int unsigned TRIM_W = 8;
    localparam int unsigned VOTE_W = 4;
    localparam int unsigned FIFO_DEPTH = 8;

    typedef logic [PHASE_W-1:0] isarq_phase_type;

    // Schedule positions within the sixteen-cycle conversion
    localparam isarq_phase_type PH_REF_ZERO = 4'h0;
    localparam isarq_phase_type PH_AUTO_ZERO = 4'h1;
    localparam isarq_phase_type PH_CALIBRATE = 4'h2;
    localparam isarq_phase_type PH_SAMPLE = 4'h3;
    localparam isarq_phase_type PH_SAR_FIRST = 4'h4;
    localparam isarq_phase_type PH_SAR_LAST = 4'he;
    localparam isarq_phase_type PH_TRANSFER = 4'hf;
    localparam isarq_phase_type PHASE_RESET = 4'h0;
    localparam int unsigned SECTION_LAG = 2;

    localparam logic [RESULT_W-1:0] SAR_START = 11'h400;
    localparam logic [RESULT_W-1:0] SAR_RESET = 11'h000;

    // Trim is signed, one step is a quarter of a data LSB
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;
    localparam logic [TRIM_W-1:0] TRIM_MAX = 8'h7f;
    localparam logic [TRIM_W-1:0] TRIM_MIN = 8'h80;
    localparam logic signed [VOTE_W-1:0] VOTE_LIMIT = 4'sh7;
    localparam logic signed [VOTE_W-1:0] VOTE_RESET = 4'sh0;

    localparam int unsigned CAL_MIN_CYCLES_DEF = 10000;
    localparam int unsigned CAL_COUNT_W = 14;

endpackage : isarq_pkg

// [core/isarq_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface isarq_fifo_if #(parameter int unsigned WIDTH = 11);
    logic wrValid;
    logic wrReady;
    logic [WIDTH-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [WIDTH-1:0] rdData;

    modport buffer (input wrValid, input wrData, input rdReady,
                    output wrReady, output rdValid, output rdData);
    modport user (output wrValid, output wrData, output rdReady,
                  input wrReady, input rdValid, input rdData);
endinterface : isarq_fifo_if
`default_nettype wire

// [core/isarq_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module isarq_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Write and read sides
    isarq_fifo_if.buffer port
);
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
    logic doWrite;
    logic doRead;

    assign port.wrReady = (count != CNT_FULL);
    assign port.rdValid = (count != '0);
    assign port.rdData = mem[rdPtr];
    assign doWrite = port.wrValid && port.wrReady;
    assign doRead = port.rdValid && port.rdReady;

    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= port.wrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == PTR_LAST) ? '0 : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == PTR_LAST) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            count <= '0;
        end else if (doWrite && !doRead) begin
            count <= count + 1'b1;
        end else if (doRead && !doWrite) begin
            count <= count - 1'b1;
        end
    end

endmodule : isarq_fifo
`default_nettype wire

// [core/isarq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module isarq_sequencer #(
    parameter int unsigned CAL_MIN_CYCLES = isarq_pkg::CAL_MIN_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Comparator decisions, one per section, latched on mclk by the analog front end
    input wire logic [isarq_pkg::NUM_SECTIONS-1:0] compDecision,
    // Pins from the capture side
    input wire logic outputEnableN,
    input wire logic captureReady,
    // Section controls towards the analog front end
    output logic [isarq_pkg::NUM_SECTIONS-1:0] refZeroSelect,
    output logic [isarq_pkg::NUM_SECTIONS-1:0] autoZeroStrobe,
    output logic [isarq_pkg::NUM_SECTIONS-1:0] calibrateStrobe,
    output logic [isarq_pkg::NUM_SECTIONS-1:0] inputSwitch,
    output logic [isarq_pkg::NUM_SECTIONS-1:0] sarActive,
    output logic [isarq_pkg::NUM_SECTIONS-1:0][isarq_pkg::RESULT_W-1:0] trialCode,
    output logic [isarq_pkg::NUM_SECTIONS-1:0][isarq_pkg::TRIM_W-1:0] offsetTrim,
    output logic [isarq_pkg::NUM_SECTIONS-1:0][isarq_pkg::TRIM_W-1:0] msbGainTrim,
    output logic [isarq_pkg::NUM_SECTIONS-1:0][isarq_pkg::TRIM_W-1:0] lsbGainTrim,
    output logic calibrated,
    // Output word pins
    output logic [isarq_pkg::DATA_W-1:0] sampleWordBits,
    output logic [isarq_pkg::DATA_W-1:0] sampleWordBitsOe,
    output logic overrangeFlag,
    output logic overrangeFlagOe,
    output logic wordValidStrobe,
    // Buffer status
    output logic bufferReady,
    output logic wordLost
);
    localparam int unsigned NS = isarq_pkg::NUM_SECTIONS;
    localparam int unsigned RW = isarq_pkg::RESULT_W;
    localparam int unsigned TW = isarq_pkg::TRIM_W;
    localparam int unsigned VW = isarq_pkg::VOTE_W;
    localparam int unsigned CW = isarq_pkg::CAL_COUNT_W;
    localparam logic [CW-1:0] CAL_DONE_COUNT = CW'(CAL_MIN_CYCLES);

    // One vote of a closed loop: votes count to the limit, then clear and move the trim one fine step
    function automatic logic [VW+TW-1:0] loopStep(
        input logic signed [VW-1:0] vote,
        input logic [TW-1:0] trim,
        input logic errorHigh
    );
        logic signed [VW-1:0] v;
        logic [TW-1:0] t;
        v = vote;
        t = trim;
        if (errorHigh) begin
            if (v == isarq_pkg::VOTE_LIMIT) begin
                v = isarq_pkg::VOTE_RESET;
                if (t != isarq_pkg::TRIM_MIN) begin
                    t = t - 1'b1;
                end
            end else begin
                v = v + 4'sh1;
            end
        end else begin
            if (v == -isarq_pkg::VOTE_LIMIT) begin
                v = isarq_pkg::VOTE_RESET;
                if (t != isarq_pkg::TRIM_MAX) begin
                    t = t + 1'b1;
                end
            end else begin
                v = v - 4'sh1;
            end
        end
        return {v, t};
    endfunction : loopStep

    isarq_pkg::isarq_phase_type phase;
    logic [CW-1:0] calCount;
    logic enableSync1;
    logic enableSync2;
    logic readySync1;
    logic readySync2;
    logic [RW-1:0] sarCode [NS];
    isarq_pkg::isarq_phase_type xferDiff;
    logic xferActive;
    logic [isarq_pkg::SEL_W-1:0] xferSel;
    logic [RW-1:0] xferWord;
    logic bypass;
    logic loadOut;
    logic [RW-1:0] loadWord;

    isarq_fifo_if #(.WIDTH(RW)) wordFifo ();

    isarq_fifo #(
        .WIDTH(RW),
        .DEPTH(isarq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .port(wordFifo.buffer)
    );

    // R03 R05 R20 wrapping phase generator
    always_ff @(posedge mclk) begin
        if (reset) begin
            phase <= isarq_pkg::PHASE_RESET;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    // R12 R13 R14 settle counter, advances only on running clock
    always_ff @(posedge mclk) begin
        if (reset) begin
            calCount <= '0;
        end else if (calCount != CAL_DONE_COUNT) begin
            calCount <= calCount + 1'b1;
        end
    end

    assign calibrated = (calCount == CAL_DONE_COUNT);

    // Pins from outside pass two flops; enable starts released
    always_ff @(posedge mclk) begin
        if (reset) begin
            enableSync1 <= 1'b1;
            enableSync2 <= 1'b1;
            readySync1 <= 1'b0;
            readySync2 <= 1'b0;
        end else begin
            enableSync1 <= outputEnableN;
            enableSync2 <= enableSync1;
            readySync1 <= captureReady;
            readySync2 <= readySync1;
        end
    end

    // R01 eight identical sections
    genvar k;
    generate
        for (k = 0; k < NS; k++) begin : g_section
            isarq_pkg::isarq_phase_type secPhase;
            isarq_pkg::isarq_phase_type bitPos;
            logic inSar;
            logic signed [VW-1:0] offsetVote;
            logic signed [VW-1:0] msbVote;
            logic signed [VW-1:0] lsbVote;
            logic gainSelMsb;
            logic [VW+TW-1:0] offsetNext;
            logic [VW+TW-1:0] msbNext;
            logic [VW+TW-1:0] lsbNext;

            // R04 each section lags its neighbour by two clocks
            assign secPhase = phase - 4'(isarq_pkg::SECTION_LAG * k);
            assign inSar = (secPhase >= isarq_pkg::PH_SAR_FIRST)
                && (secPhase <= isarq_pkg::PH_SAR_LAST);
            assign bitPos = isarq_pkg::PH_SAR_LAST - secPhase;

            // R02 schedule decode
            assign refZeroSelect[k] = (secPhase == isarq_pkg::PH_REF_ZERO);
            assign autoZeroStrobe[k] = (secPhase == isarq_pkg::PH_AUTO_ZERO);
            assign calibrateStrobe[k] = (secPhase == isarq_pkg::PH_CALIBRATE);
            // R11 input switch closed only while sampling
            assign inputSwitch[k] = (secPhase == isarq_pkg::PH_SAMPLE);
            assign sarActive[k] = inSar;
            assign trialCode[k] = sarCode[k];

            // R02 eleven-bit approximation, one bit per cycle
            always_ff @(posedge mclk) begin
                if (reset) begin
                    sarCode[k] <= isarq_pkg::SAR_RESET;
                end else if (secPhase == isarq_pkg::PH_SAMPLE) begin
                    sarCode[k] <= isarq_pkg::SAR_START;
                end else if (inSar) begin
                    sarCode[k][bitPos] <= compDecision[k];
                    if (bitPos != '0) begin
                        sarCode[k][bitPos - 1'b1] <= 1'b1;
                    end
                end
            end

            assign offsetNext = loopStep(offsetVote, offsetTrim[k], compDecision[k]);
            assign msbNext = loopStep(msbVote, msbGainTrim[k], compDecision[k]);
            assign lsbNext = loopStep(lsbVote, lsbGainTrim[k], compDecision[k]);

            // R09 R12 R15 auto-zero integrates votes against reference zero
            always_ff @(posedge mclk) begin
                if (reset) begin
                    offsetVote <= isarq_pkg::VOTE_RESET;
                    offsetTrim[k] <= isarq_pkg::TRIM_RESET;
                end else if (autoZeroStrobe[k]) begin
                    offsetVote <= offsetNext[VW+TW-1:TW];
                    offsetTrim[k] <= offsetNext[TW-1:0];
                end
            end

            // R10 R15 gain loop alternates MSB and LSB reference per conversion
            always_ff @(posedge mclk) begin
                if (reset) begin
                    gainSelMsb <= 1'b1;
                    msbVote <= isarq_pkg::VOTE_RESET;
                    lsbVote <= isarq_pkg::VOTE_RESET;
                    msbGainTrim[k] <= isarq_pkg::TRIM_RESET;
                    lsbGainTrim[k] <= isarq_pkg::TRIM_RESET;
                end else if (calibrateStrobe[k]) begin
                    gainSelMsb <= !gainSelMsb;
                    if (gainSelMsb) begin
                        msbVote <= msbNext[VW+TW-1:TW];
                        msbGainTrim[k] <= msbNext[TW-1:0];
                    end else begin
                        lsbVote <= lsbNext[VW+TW-1:TW];
                        lsbGainTrim[k] <= lsbNext[TW-1:0];
                    end
                end
            end
        end
    endgenerate

    // R21 R06 the section in its transfer cycle, one every two clocks
    assign xferDiff = phase - isarq_pkg::PH_TRANSFER;
    assign xferActive = !xferDiff[0];
    assign xferSel = xferDiff[3:1];
    // R08 eleven-bit eight-to-one multiplexer
    assign xferWord = sarCode[xferSel];

    // Empty buffer and a willing capture side skip the queue to hold latency
    assign bypass = xferActive && !wordFifo.rdValid && readySync2;
    assign wordFifo.wrValid = xferActive && !bypass;
    assign wordFifo.wrData = xferWord;
    assign wordFifo.rdReady = readySync2;
    assign bufferReady = wordFifo.wrReady;
    assign loadOut = bypass || (wordFifo.rdValid && readySync2);
    assign loadWord = bypass ? xferWord : wordFifo.rdData;

    // A full buffer drops the newest word, since conversion cannot pause
    always_ff @(posedge mclk) begin
        if (reset) begin
            wordLost <= 1'b0;
        end else if (wordFifo.wrValid && !wordFifo.wrReady) begin
            wordLost <= 1'b1;
        end
    end

    // R07 R16 R17 R18 registered word, straight binary, overrange clamps to ones
    always_ff @(posedge mclk) begin
        if (reset) begin
            sampleWordBits <= '0;
            overrangeFlag <= 1'b0;
        end else if (loadOut) begin
            overrangeFlag <= loadWord[RW-1];
            sampleWordBits <= loadWord[RW-1] ? '1 : loadWord[isarq_pkg::DATA_W-1:0];
        end
    end

    // R19 one-clock strobe per new word
    always_ff @(posedge mclk) begin
        if (reset) begin
            wordValidStrobe <= 1'b0;
        end else begin
            wordValidStrobe <= loadOut;
        end
    end

    // R16 pins released while the enable pin is high
    assign sampleWordBitsOe = {isarq_pkg::DATA_W{!enableSync2}};
    assign overrangeFlagOe = !enableSync2;

endmodule : isarq_sequencer
`default_nettype wire

// [testbench/isarq_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module isarq_checker #(
    parameter int unsigned CAL_MIN_CYCLES = 20
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Capture side pins
    input wire logic outputEnableN,
    input wire logic captureReady,
    // Section controls
    input wire logic [7:0] refZeroSelect,
    input wire logic [7:0] autoZeroStrobe,
    input wire logic [7:0] calibrateStrobe,
    input wire logic [7:0] inputSwitch,
    input wire logic [7:0] sarActive,
    input wire logic calibrated,
    // Output word
    input wire logic [9:0] sampleWordBits,
    input wire logic [9:0] sampleWordBitsOe,
    input wire logic overrangeFlag,
    input wire logic overrangeFlagOe,
    input wire logic wordValidStrobe
);
    logic [5:0] readyRun;
    logic [15:0] runCycles;

    // Long ready runs mean the buffer has drained, so latency is exact
    always_ff @(posedge mclk) begin
        if (reset || !captureReady) readyRun <= 6'h00;
        else if (readyRun != 6'h3f) readyRun <= readyRun + 6'h01;
    end
    always_ff @(posedge mclk) begin
        if (reset) runCycles <= 16'h0000;
        else if (runCycles != 16'hffff) runCycles <= runCycles + 16'h0001;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    chk_input_onehot: assert property ($onehot0(inputSwitch))
        else $error("input switch not one-hot");
    chk_sample_rotate: assert property (inputSwitch != 8'h00 |-> ##1 inputSwitch == 8'h00
        ##1 inputSwitch == {$past(inputSwitch[6:0], 2), $past(inputSwitch[7], 2)})
        else $error("sampling order broken");
    chk_schedule_steps: assert property (refZeroSelect != 8'h00
        |=> autoZeroStrobe == $past(refZeroSelect) ##1 calibrateStrobe == $past(refZeroSelect, 2)
        ##1 inputSwitch == $past(refZeroSelect, 3))
        else $error("step order broken");
    chk_sar_span: assert property (inputSwitch[0] |=> sarActive[0] [*8]
        ##3 sarActive[0] ##1 !sarActive[0])
        else $error("conversion span wrong");
    chk_phase_wrap: assert property (inputSwitch[0] |=> !inputSwitch[0] [*8] ##8 inputSwitch[0])
        else $error("schedule period wrong");
    chk_reset_phase: assert property ($fell(reset) |-> refZeroSelect == 8'h01)
        else $error("start phase wrong");
    chk_word_latency: assert property ((inputSwitch != 8'h00 && readyRun >= 48)
        |-> ##13 (wordValidStrobe || readyRun < 15))
        else $error("word latency wrong");
    chk_strobe_single: assert property (wordValidStrobe && readyRun >= 48 |=> !wordValidStrobe)
        else $error("strobe too long");
    chk_overrange_ones: assert property (overrangeFlag |-> sampleWordBits == 10'h3ff)
        else $error("overrange data not ones");
    chk_oe_drive: assert property (!outputEnableN [*3]
        |-> sampleWordBitsOe == 10'h3ff && overrangeFlagOe)
        else $error("outputs not driven");
    chk_oe_release: assert property (outputEnableN [*3]
        |-> sampleWordBitsOe == 10'h000 && !overrangeFlagOe)
        else $error("outputs not released");
    chk_cal_time: assert property (calibrated ? runCycles >= CAL_MIN_CYCLES - 2
        : runCycles <= CAL_MIN_CYCLES + 2)
        else $error("calibrated flag timing wrong");
endmodule : isarq_checker

bind isarq_sequencer isarq_checker #(.CAL_MIN_CYCLES(CAL_MIN_CYCLES)) u_chk (.mclk, .reset,
    .outputEnableN, .captureReady, .refZeroSelect, .autoZeroStrobe, .calibrateStrobe,
    .inputSwitch, .sarActive, .calibrated, .sampleWordBits, .sampleWordBitsOe,
    .overrangeFlag, .overrangeFlagOe, .wordValidStrobe);
`default_nettype wire

// [testbench/isarq_capture_model.sv]
`timescale 1ns/1ps
`default_nettype none
module isarq_capture_model (
    // Clock and stall control
    input wire logic mclk,
    input wire logic stall,
    // Word pins
    input wire logic [9:0] sampleWordBits,
    input wire logic [9:0] sampleWordBitsOe,
    input wire logic overrangeFlag,
    input wire logic overrangeFlagOe,
    input wire logic wordValidStrobe,
    output logic captureReady
);
    logic [10:0] lastBus = 11'h000;
    logic [10:0] words[$];
    wire logic [10:0] oe = {overrangeFlagOe, sampleWordBitsOe};
    // Released lines show the inverse, never a stale copy
    wire logic [10:0] busLevel = (oe & {overrangeFlag, sampleWordBits}) | (~oe & ~lastBus);

    initial captureReady = 1'b0;
    always @(posedge mclk) begin
        lastBus <= busLevel;
        captureReady <= !stall;
        if (wordValidStrobe) words.push_back(busLevel);
    end
endmodule : isarq_capture_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] compDecision = 8'h00;
    logic outputEnableN = 1'b0;
    logic stall = 1'b0;
    logic calErr = 1'b0;
    logic [3:0] cur = 4'h0;
    logic [10:0] code [8] = '{11'h000, 11'h001, 11'h2aa, 11'h7ff, 11'h3ff, 11'h455, 11'h155,
        11'h200};
    int errTotal = 0;
    int testsRun = 0;
    wire logic captureReady;
    wire logic [9:0] sampleWordBits;
    wire logic [9:0] sampleWordBitsOe;
    wire logic overrangeFlag;
    wire logic overrangeFlagOe;
    wire logic wordValidStrobe;
    wire logic bufferReady;
    wire logic wordLost;
    wire logic calibrated;
    wire logic [7:0][7:0] offsetTrim;
    wire logic [7:0][7:0] msbGainTrim;
    wire logic [7:0][7:0] lsbGainTrim;

    isarq_sequencer #(.CAL_MIN_CYCLES(20)) u_dut (.mclk(mclk), .reset(reset),
        .compDecision(compDecision), .outputEnableN(outputEnableN),
        .captureReady(captureReady), .refZeroSelect(), .autoZeroStrobe(),
        .calibrateStrobe(), .inputSwitch(), .sarActive(), .trialCode(),
        .offsetTrim(offsetTrim), .msbGainTrim(msbGainTrim), .lsbGainTrim(lsbGainTrim),
        .calibrated(calibrated), .sampleWordBits(sampleWordBits),
        .sampleWordBitsOe(sampleWordBitsOe), .overrangeFlag(overrangeFlag),
        .overrangeFlagOe(overrangeFlagOe), .wordValidStrobe(wordValidStrobe),
        .bufferReady(bufferReady), .wordLost(wordLost));
    isarq_capture_model u_cap (.mclk(mclk), .stall(stall), .sampleWordBits(sampleWordBits),
        .sampleWordBitsOe(sampleWordBitsOe), .overrangeFlag(overrangeFlag),
        .overrangeFlagOe(overrangeFlagOe), .wordValidStrobe(wordValidStrobe),
        .captureReady(captureReady));

    always #25 mclk = ~mclk;

    // Comparator answers a target code, MSB first, per section slot
    function automatic logic pick(input int k, input logic [3:0] ph);
        logic [3:0] p;
        p = ph - 4'(2 * k);
        if (p >= 4'h4 && p <= 4'he) return code[k][4'he - p];
        return (p == 4'h1 || p == 4'h2) ? calErr : 1'b0;
    endfunction : pick

    function automatic logic [10:0] expWord(input logic [10:0] c);
        return c[10] ? 11'h7ff : c;
    endfunction : expWord

    always @(posedge mclk) begin
        cur <= reset ? 4'h0 : cur + 4'h1;
        for (int k = 0; k < 8; k++) compDecision[k] <= pick(k, reset ? 4'h0 : cur + 4'h1);
    end

    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask : cycles

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : giveVerdict

    task automatic waitWords(input int n);
        int t;
        t = 0;
        while (u_cap.words.size() < n && t < 400) begin
            @(posedge mclk);
            t++;
        end
        if (t == 400) begin
            errTotal++;
            $display("Error word count expected %0d seen %0d", n, u_cap.words.size());
            giveVerdict();
        end
    endtask : waitWords

    task automatic checkRotation(input int n);
        int s;
        s = 0;
        for (int j = 0; j < 8; j++) begin
            if (expWord(code[j]) == u_cap.words[0] && expWord(code[(j + 1) % 8]) == u_cap.words[1])
                s = j;
        end
        for (int i = 0; i < n; i++) begin
            check("word", expWord(code[(s + i) % 8]), u_cap.words[i]);
        end
    endtask : checkRotation

    task automatic resetDut();
        reset <= 1'b1;
        cycles(3);
        reset <= 1'b0;
    endtask : resetDut

    task automatic testCal();
        resetDut();
        cycles(5);
        @(negedge mclk);
        check("calibrated early", 11'h000, {10'h000, calibrated});
        cycles(30);
        @(negedge mclk);
        check("calibrated late", 11'h001, {10'h000, calibrated});
        $display("testCal done");
    endtask : testCal

    task automatic testOrder();
        cycles(60);
        u_cap.words.delete();
        waitWords(16);
        checkRotation(16);
        $display("testOrder done");
    endtask : testOrder

    task automatic testOe();
        @(posedge mclk);
        outputEnableN <= 1'b1;
        cycles(4);
        @(negedge mclk);
        check("enables off", 11'h000, {overrangeFlagOe, sampleWordBitsOe});
        @(posedge mclk);
        outputEnableN <= 1'b0;
        cycles(4);
        @(negedge mclk);
        check("enables on", 11'h7ff, {overrangeFlagOe, sampleWordBitsOe});
        $display("testOe done");
    endtask : testOe

    task automatic testOverflow();
        @(posedge mclk);
        stall <= 1'b1;
        cycles(60);
        @(negedge mclk);
        check("buffer full", 11'h002, {9'h000, wordLost, bufferReady});
        @(posedge mclk);
        u_cap.words.delete();
        stall <= 1'b0;
        waitWords(8);
        checkRotation(8);
        cycles(40);
        @(negedge mclk);
        check("buffer drained", 11'h003, {9'h000, wordLost, bufferReady});
        @(posedge mclk);
        resetDut();
        @(negedge mclk);
        check("lost cleared", 11'h000, {10'h000, wordLost});
        $display("testOverflow done");
    endtask : testOverflow

    task automatic testTrim();
        logic [7:0] a;
        @(posedge mclk);
        calErr <= 1'b1;
        cycles(600);
        @(negedge mclk);
        check("offset sign", 11'h001, {10'h000, offsetTrim[0][7]});
        check("gain signs", 11'h003, {9'h000, msbGainTrim[0][7], lsbGainTrim[0][7]});
        a = offsetTrim[0];
        @(posedge mclk);
        calErr <= 1'b0;
        cycles(600);
        @(negedge mclk);
        check("offset rise", 11'h001, {10'h000, $signed(offsetTrim[0]) > $signed(a)});
        $display("testTrim done");
    endtask : testTrim

    initial begin
        testCal();
        testOrder();
        testOe();
        testOverflow();
        testTrim();
        giveVerdict();
    end
endmodule : tb
`default_nettype wire
